// [core/psr_regs.vh]
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PSR_OFS_PMU0 8'h00
`define PSR_OFS_PMU1 8'h04
`define PSR_OFS_PMU2 8'h08
`define PSR_OFS_PMU3 8'h0c
`define PSR_OFS_SYSCTL 8'h10
`define PSR_OFS_RB0 8'h20
`define PSR_OFS_RB1 8'h24
`define PSR_OFS_RB2 8'h28
`define PSR_OFS_RB3 8'h2c
`define PSR_OFS_CMPSTAT 8'h30
`define PSR_OFS_ALMSTAT 8'h34
`define PSR_OFS_IRQSTAT 8'h38
`define PSR_OFS_IRQMASK 8'h3c

// ****************************************************************
// Readback word fields
// ****************************************************************
`define PSR_WORD_W 24
`define PSR_TYPE_HI 23
`define PSR_TYPE_LO 22
`define PSR_SETUP_HI 21
`define PSR_SETUP_LO 7
`define PSR_RSVD_BIT 18
`define PSR_BIT_FIN 12
`define PSR_BIT_SF 11
`define PSR_BIT_SS 10
`define PSR_BIT_CL 9
`define PSR_BIT_CPEN 8
`define PSR_BIT_CMPV 7
`define PSR_BIT_TLATCH 6
`define PSR_BIT_TLIVE 5
`define PSR_BIT_CLEAR 6
`define PSR_CMP_HI 21
`define PSR_CMP_LO 14
`define PSR_ALM_TLATCH 21
`define PSR_ALM_TLIVE 20

// ****************************************************************
// Word type codes and reset values
// ****************************************************************
`define PSR_TYPE_PMU 2'h0
`define PSR_TYPE_CMP 2'h1
`define PSR_TYPE_ALM 2'h3
`define PSR_SETUP_RST 15'h0000
`define PSR_IRQ_RST 3'h0
`define PSR_IRQ_TEMP 0
`define PSR_IRQ_CLAMP 1
`define PSR_IRQ_GUARD 2

`endif

// [core/psr_sync2.v]
// ****************************************************************
// Two-stage synchroniser for pin levels
// ****************************************************************
module psr_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end

endmodule

// [core/psr_readback.v]
// Operation
// - Each readback returns one 24-bit word
// - Bit 12 shows force input switch
// - Bits 11,10 show system force/sense connection
// - Bit 9 shows current clamp enable
// - Clamp bit follows last writer, either register
// - Bit 8 shows comparator output enable
// - Comparator enable follows last writer, either register
// - Bit 7 one for voltage compare
// - Bits 6,5 carry latched and live thermal alarm
// - Writing clear bit resets latched thermal alarm
// - Comparator word read-only, type bits 0,1
// - Bits 21..14 hold low/high comparator pairs
// - Separate alarm word; thermal mirrored per channel
module psr_readback #(
    parameter CHANNELS = 4
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rd_data,
    input wire thermal_alarm_pin,
    input wire [3:0] clamp_alarm_pin,
    input wire [3:0] guard_alarm_pin,
    input wire [3:0] low_comparator_pin,
    input wire [3:0] high_comparator_pin,
    output reg [3:0] channel_enable,
    output reg [3:0] force_input_switch,
    output reg [3:0] system_force_connect,
    output reg [3:0] system_sense_connect,
    output reg [3:0] current_clamp_enable,
    output reg [3:0] comparator_output_enable,
    output reg [3:0] compare_voltage,
    output wire irq
);

`include "psr_regs.vh"

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire thermal_alarm_live;
    wire [3:0] clamp_live;
    wire [3:0] guard_live;
    wire [3:0] low_cmp;
    wire [3:0] high_cmp;

    psr_sync2 #(
        .WIDTH(17)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({thermal_alarm_pin, clamp_alarm_pin, guard_alarm_pin,
            low_comparator_pin, high_comparator_pin}),
        .sync_out({thermal_alarm_live, clamp_live, guard_live,
            low_cmp, high_cmp})
    );

    // ****************************************************************
    // Channel setup storage
    // ****************************************************************
    // Setup fields are held in the same layout as readback bits 21..7,
    // so a readback is a straight copy of the stored field.
    reg [14:0] setup0;
    reg [14:0] setup1;
    reg [14:0] setup2;
    reg [14:0] setup3;
    reg [14:0] next_setup0;
    reg [14:0] next_setup1;
    reg [14:0] next_setup2;
    reg [14:0] next_setup3;

    wire pmu_wr0;
    wire pmu_wr1;
    wire pmu_wr2;
    wire pmu_wr3;
    wire sys_wr;
    wire [14:0] wr_setup;
    wire [14:0] rsvd_mask;
    wire clr_alarm;

    assign pmu_wr0 = wr_en && (addr == `PSR_OFS_PMU0);
    assign pmu_wr1 = wr_en && (addr == `PSR_OFS_PMU1);
    assign pmu_wr2 = wr_en && (addr == `PSR_OFS_PMU2);
    assign pmu_wr3 = wr_en && (addr == `PSR_OFS_PMU3);
    assign sys_wr = wr_en && (addr == `PSR_OFS_SYSCTL);

    // The reserved position never stores a one.
    assign rsvd_mask = ~(15'h0001 << (`PSR_RSVD_BIT - `PSR_SETUP_LO));
    assign wr_setup = wr_data[`PSR_SETUP_HI:`PSR_SETUP_LO] & rsvd_mask;

    assign clr_alarm = (pmu_wr0 || pmu_wr1 || pmu_wr2 || pmu_wr3)
        && wr_data[`PSR_BIT_CLEAR];

    localparam CL_POS = `PSR_BIT_CL - `PSR_SETUP_LO;
    localparam CP_POS = `PSR_BIT_CPEN - `PSR_SETUP_LO;

    // A system control write updates clamp and comparator enables of
    // the channels picked by its low four bits; a channel register
    // write updates all of that channel's fields. Only one strobe can
    // be high per cycle, so whichever came last is what is held.
    always @*
    begin
        next_setup0 = setup0;
        next_setup1 = setup1;
        next_setup2 = setup2;
        next_setup3 = setup3;
        if (pmu_wr0)
            next_setup0 = wr_setup;
        if (pmu_wr1)
            next_setup1 = wr_setup;
        if (pmu_wr2)
            next_setup2 = wr_setup;
        if (pmu_wr3)
            next_setup3 = wr_setup;
        if (sys_wr)
        begin
            if (wr_data[0])
            begin
                next_setup0[CL_POS] = wr_data[`PSR_BIT_CL];
                next_setup0[CP_POS] = wr_data[`PSR_BIT_CPEN];
            end
            if (wr_data[1])
            begin
                next_setup1[CL_POS] = wr_data[`PSR_BIT_CL];
                next_setup1[CP_POS] = wr_data[`PSR_BIT_CPEN];
            end
            if (wr_data[2])
            begin
                next_setup2[CL_POS] = wr_data[`PSR_BIT_CL];
                next_setup2[CP_POS] = wr_data[`PSR_BIT_CPEN];
            end
            if (wr_data[3])
            begin
                next_setup3[CL_POS] = wr_data[`PSR_BIT_CL];
                next_setup3[CP_POS] = wr_data[`PSR_BIT_CPEN];
            end
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            setup0 <= `PSR_SETUP_RST;
            setup1 <= `PSR_SETUP_RST;
            setup2 <= `PSR_SETUP_RST;
            setup3 <= `PSR_SETUP_RST;
        end
        else
        begin
            setup0 <= next_setup0;
            setup1 <= next_setup1;
            setup2 <= next_setup2;
            setup3 <= next_setup3;
        end
    end

    // ****************************************************************
    // Control outputs to the analog channels
    // ****************************************************************
    localparam EN_POS = 14;
    localparam FIN_POS = `PSR_BIT_FIN - `PSR_SETUP_LO;
    localparam SF_POS = `PSR_BIT_SF - `PSR_SETUP_LO;
    localparam SS_POS = `PSR_BIT_SS - `PSR_SETUP_LO;
    localparam CV_POS = `PSR_BIT_CMPV - `PSR_SETUP_LO;

    always @(posedge clk)
    begin
        if (rst)
        begin
            channel_enable <= 4'h0;
            force_input_switch <= 4'h0;
            system_force_connect <= 4'h0;
            system_sense_connect <= 4'h0;
            current_clamp_enable <= 4'h0;
            comparator_output_enable <= 4'h0;
            compare_voltage <= 4'h0;
        end
        else
        begin
            channel_enable <= {next_setup3[EN_POS], next_setup2[EN_POS],
                next_setup1[EN_POS], next_setup0[EN_POS]};
            force_input_switch <= {next_setup3[FIN_POS],
                next_setup2[FIN_POS], next_setup1[FIN_POS],
                next_setup0[FIN_POS]};
            system_force_connect <= {next_setup3[SF_POS],
                next_setup2[SF_POS], next_setup1[SF_POS],
                next_setup0[SF_POS]};
            system_sense_connect <= {next_setup3[SS_POS],
                next_setup2[SS_POS], next_setup1[SS_POS],
                next_setup0[SS_POS]};
            current_clamp_enable <= {next_setup3[CL_POS],
                next_setup2[CL_POS], next_setup1[CL_POS],
                next_setup0[CL_POS]};
            comparator_output_enable <= {next_setup3[CP_POS],
                next_setup2[CP_POS], next_setup1[CP_POS],
                next_setup0[CP_POS]};
            compare_voltage <= {next_setup3[CV_POS], next_setup2[CV_POS],
                next_setup1[CV_POS], next_setup0[CV_POS]};
        end
    end

    // ****************************************************************
    // Alarm latches
    // ****************************************************************
    reg thermal_alarm_latched;
    reg [3:0] clamp_latched;
    reg [3:0] guard_latched;

    // A live alarm in the clearing cycle keeps the latch set, so no
    // event slips through a clear.
    always @(posedge clk)
    begin
        if (rst)
        begin
            thermal_alarm_latched <= 1'b0;
            clamp_latched <= 4'h0;
            guard_latched <= 4'h0;
        end
        else
        begin
            thermal_alarm_latched <= thermal_alarm_live
                || (thermal_alarm_latched && !clr_alarm);
            clamp_latched <= clamp_live
                | (clamp_latched & {4{!clr_alarm}});
            guard_latched <= guard_live
                | (guard_latched & {4{!clr_alarm}});
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg thermal_d;
    reg [3:0] clamp_d;
    reg [3:0] guard_d;
    wire [2:0] irq_event;
    wire [2:0] irq_clear;

    assign irq_event[`PSR_IRQ_TEMP] = thermal_alarm_live && !thermal_d;
    assign irq_event[`PSR_IRQ_CLAMP] = |(clamp_live & ~clamp_d);
    assign irq_event[`PSR_IRQ_GUARD] = |(guard_live & ~guard_d);
    assign irq_clear = (wr_en && (addr == `PSR_OFS_IRQSTAT))
        ? wr_data[2:0] : 3'h0;
    assign irq = |(irq_status & irq_mask);

    always @(posedge clk)
    begin
        if (rst)
        begin
            thermal_d <= 1'b0;
            clamp_d <= 4'h0;
            guard_d <= 4'h0;
            irq_status <= `PSR_IRQ_RST;
            irq_mask <= `PSR_IRQ_RST;
        end
        else
        begin
            thermal_d <= thermal_alarm_live;
            clamp_d <= clamp_live;
            guard_d <= guard_live;
            irq_status <= irq_event | (irq_status & ~irq_clear);
            if (wr_en && (addr == `PSR_OFS_IRQMASK))
                irq_mask <= wr_data[2:0];
        end
    end

    // ****************************************************************
    // Readback words
    // ****************************************************************
    wire [23:0] pmu_word0;
    wire [23:0] pmu_word1;
    wire [23:0] pmu_word2;
    wire [23:0] pmu_word3;
    wire [23:0] cmp_word;
    wire [23:0] alm_word;
    wire [1:0] alarm_pair;

    assign alarm_pair = {thermal_alarm_latched, thermal_alarm_live};

    assign pmu_word0 = {`PSR_TYPE_PMU, setup0, alarm_pair, 5'h00};
    assign pmu_word1 = {`PSR_TYPE_PMU, setup1, alarm_pair, 5'h00};
    assign pmu_word2 = {`PSR_TYPE_PMU, setup2, alarm_pair, 5'h00};
    assign pmu_word3 = {`PSR_TYPE_PMU, setup3, alarm_pair, 5'h00};

    assign cmp_word = {`PSR_TYPE_CMP,
        low_cmp[0], high_cmp[0], low_cmp[1], high_cmp[1],
        low_cmp[2], high_cmp[2], low_cmp[3], high_cmp[3], 14'h0000};

    assign alm_word = {`PSR_TYPE_ALM, alarm_pair,
        guard_latched[0], guard_live[0], guard_latched[1], guard_live[1],
        guard_latched[2], guard_live[2], guard_latched[3], guard_live[3],
        clamp_latched[0], clamp_live[0], clamp_latched[1], clamp_live[1],
        clamp_latched[2], clamp_live[2], clamp_latched[3], clamp_live[3],
        4'h0};

    // ****************************************************************
    // Read port
    // ****************************************************************
    reg [31:0] next_rd_data;

    always @*
    begin
        next_rd_data = 32'h0000_0000;
        if (rd_en)
        begin
            case (addr)
                `PSR_OFS_PMU0: next_rd_data = {8'h00, pmu_word0};
                `PSR_OFS_PMU1: next_rd_data = {8'h00, pmu_word1};
                `PSR_OFS_PMU2: next_rd_data = {8'h00, pmu_word2};
                `PSR_OFS_PMU3: next_rd_data = {8'h00, pmu_word3};
                `PSR_OFS_RB0: next_rd_data = {8'h00, pmu_word0};
                `PSR_OFS_RB1: next_rd_data = {8'h00, pmu_word1};
                `PSR_OFS_RB2: next_rd_data = {8'h00, pmu_word2};
                `PSR_OFS_RB3: next_rd_data = {8'h00, pmu_word3};
                `PSR_OFS_CMPSTAT: next_rd_data = {8'h00, cmp_word};
                `PSR_OFS_ALMSTAT: next_rd_data = {8'h00, alm_word};
                `PSR_OFS_IRQSTAT: next_rd_data = {29'h0, irq_status};
                `PSR_OFS_IRQMASK: next_rd_data = {29'h0, irq_mask};
                default: next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Read data is zero except in the cycle right after a read.
    always @(posedge clk)
    begin
        if (rst)
            rd_data <= 32'h0000_0000;
        else
            rd_data <= next_rd_data;
    end

endmodule

// [tb/psr_readback_asserts.sv]
module psr_readback_asserts #(
    parameter CHANNELS = 4
) (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rd_data,
    input wire thermal_alarm_pin,
    input wire [3:0] low_comparator_pin,
    input wire [3:0] high_comparator_pin,
    input wire [3:0] force_input_switch,
    input wire [3:0] system_force_connect,
    input wire [3:0] system_sense_connect,
    input wire [3:0] current_clamp_enable,
    input wire [3:0] comparator_output_enable,
    input wire [3:0] compare_voltage
);
    timeunit 1ns;
    timeprecision 100ps;
    wire [3:0] lo = low_comparator_pin;
    wire [3:0] hi = high_comparator_pin;
    wire [7:0] pair = {lo[0], hi[0], lo[1], hi[1], lo[2], hi[2], lo[3], hi[3]};
    wire tp = thermal_alarm_pin;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmp_read;
        rd_en && addr == 8'h30;
    endsequence
    sequence s_rb_read;
        rd_en && addr[7:4] == 4'h2 && addr[1:0] == 2'b00;
    endsequence
    AST_RD_IDLE: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data not idle zero");
    AST_TOP_ZERO: assert property (rd_data[31:24] == 8'h0)
        else $error("read data above word width");
    AST_RB_FRAME: assert property (s_rb_read |=>
        rd_data[23:22] == 2'b00 && rd_data[4:0] == 5'h0)
        else $error("setup readback frame wrong");
    AST_CMP_FRAME: assert property (s_cmp_read |=>
        rd_data[23:22] == 2'b01 && rd_data[13:0] == 14'h0)
        else $error("comparator word frame wrong");
    // Pins must rest three samples so the two sync stages have settled.
    AST_CMP_LIVE: assert property (s_cmp_read ##0
        ($stable(pair) && $past(pair, 2) == pair)
        |=> rd_data[21:14] == $past(pair))
        else $error("comparator pairs wrong");
    // The latch trails the live stage by one more cycle, so the pin must
    // rest four samples before the latched bit is certain.
    AST_THERM_LIVE: assert property (s_rb_read ##0
        ($stable(tp) && $past(tp, 2) == tp && $past(tp, 3) == tp)
        |=> rd_data[5] == $past(tp) && (rd_data[6] || !rd_data[5]))
        else $error("thermal bits wrong");
    AST_SETUP_OUT: assert property (wr_en && addr == 8'h00 |=>
        {force_input_switch[0], system_force_connect[0],
        system_sense_connect[0], current_clamp_enable[0],
        comparator_output_enable[0], compare_voltage[0]}
        == $past(wr_data[12:7]))
        else $error("setup outputs not loaded");
    AST_SYSCTL: assert property (wr_en && addr == 8'h10
        && wr_data[1] |=> current_clamp_enable[1] == $past(wr_data[9])
        && comparator_output_enable[1] == $past(wr_data[8]))
        else $error("system control not applied");
    AST_RB_FIELDS: assert property (rd_en && addr == 8'h24 |=>
        rd_data[12:7] == {$past(force_input_switch[1]),
        $past(system_force_connect[1]), $past(system_sense_connect[1]),
        $past(current_clamp_enable[1]), $past(comparator_output_enable[1]),
        $past(compare_voltage[1])})
        else $error("readback fields differ from outputs");
endmodule

bind psr_readback psr_readback_asserts #(.CHANNELS(CHANNELS))
    u_psr_readback_asserts (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .thermal_alarm_pin(thermal_alarm_pin),
    .low_comparator_pin(low_comparator_pin),
    .high_comparator_pin(high_comparator_pin),
    .force_input_switch(force_input_switch),
    .system_force_connect(system_force_connect),
    .system_sense_connect(system_sense_connect),
    .current_clamp_enable(current_clamp_enable),
    .comparator_output_enable(comparator_output_enable),
    .compare_voltage(compare_voltage));

// [tb/psr_pin_model.sv]
// ****************************************************************
// Analog front end pins: comparators and alarm levels
// ****************************************************************
module psr_pin_model (
    input wire clk,
    input wire rst,
    input wire [16:0] pin_req,
    output logic [16:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // Levels take pin_req on the clock edge itself, with no delay, one cycle after the request.
    always @(posedge clk)
    begin
        if (rst)
            pins <= 17'h0;
        else
            pins <= pin_req;
    end
endmodule

// [tb/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, wr_en, rd_en, irq;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data, p [4];
    logic [16:0] pv, pins;
    logic [27:0] unused;
    int fail_count = 0, checked = 0, cyc = 0;
    psr_pin_model u_psr_pin_model (.clk(clk), .rst(rst), .pin_req(pv),
        .pins(pins));
    psr_readback u_psr_readback (.clk(clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .thermal_alarm_pin(pins[16]), .clamp_alarm_pin(pins[11:8]),
        .guard_alarm_pin(pins[15:12]), .low_comparator_pin(pins[3:0]),
        .high_comparator_pin(pins[7:4]), .channel_enable(unused[3:0]),
        .force_input_switch(unused[7:4]), .system_force_connect(unused[11:8]),
        .system_sense_connect(unused[15:12]),
        .current_clamp_enable(unused[19:16]),
        .comparator_output_enable(unused[23:20]),
        .compare_voltage(unused[27:24]), .irq(irq));
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task end_of_test;
        $display("checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            end_of_test;
        end
    end
    task chk(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_en <= 1;
        addr <= a;
        @(posedge clk);
        rd_en <= 0;
        #1;
        chk($sformatf("read %h", a), rd_data, exp);
    endtask
    function logic [31:0] pmu(input logic [31:0] d, input logic tl, tv);
        pmu = {10'h0, d[21:19], 1'b0, d[17:7], tl, tv, 5'h0};
    endfunction
    function logic [31:0] cmpw(input logic [3:0] l, h);
        cmpw = 32'h00400000;
        for (int n = 0; n < 4; n++)
            cmpw[21 - 2 * n -: 2] = {l[n], h[n]};
    endfunction
    task settle;
        repeat (4) @(posedge clk);
    endtask
    initial
    begin
        rst = 1;
        wr_en = 0;
        rd_en = 0;
        addr = 8'h0;
        wr_data = 32'h0;
        pv = 17'h0;
        p = '{32'hffffffbf, 32'h00155500, 32'h002aaa80, 32'h00000000};
        repeat (8) @(posedge clk);
        rst <= 0;
        rdc(8'h20, 32'h0);
        for (int n = 0; n < 4; n++)
            wr(8'(4 * n), p[n]);
        for (int n = 0; n < 4; n++)
        begin
            rdc(8'(4 * n), pmu(p[n], 0, 0));
            rdc(8'(8'h20 + 4 * n), pmu(p[n], 0, 0));
        end
        chk("channel enable", {28'h0, unused[3:0]}, 32'h5);
        wr(8'h10, 32'h0000020a);
        rdc(8'h24, pmu(32'h00155600, 0, 0));
        rdc(8'h2c, pmu(32'h00000200, 0, 0));
        rdc(8'h20, pmu(p[0], 0, 0));
        rdc(8'h10, 32'h0);
        wr(8'h04, p[1]);
        rdc(8'h24, pmu(p[1], 0, 0));
        wr(8'h30, 32'hffffffff);
        for (int i = 0; i < 4; i++)
        begin
            pv[7:0] <= {4'(4'h8 >> i) | 4'(i), 4'(4'h5 << i)};
            settle;
            rdc(8'h30, cmpw(4'(4'h5 << i), 4'(4'h8 >> i) | 4'(i)));
        end
        pv <= 17'h10000;
        settle;
        rdc(8'h28, pmu(p[2], 1, 1));
        chk("irq masked", {31'h0, irq}, 32'h0);
        pv <= 17'h01100;
        settle;
        rdc(8'h2c, pmu(32'h00000200, 1, 0));
        rdc(8'h34, 32'h00ec0c00);
        rdc(8'h38, 32'h7);
        wr(8'h3c, 32'h1);
        // The mask lands on this very edge, so look once it has settled.
        #1;
        chk("irq", {31'h0, irq}, 32'h1);
        wr(8'h08, p[2] | 32'h40);
        rdc(8'h28, pmu(p[2], 0, 0));
        // Clamp and guard pins still stand high, so those latches set again.
        rdc(8'h34, 32'h00cc0c00);
        wr(8'h38, 32'h7);
        rdc(8'h38, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        wr(8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
        end_of_test;
    end
endmodule
